// File: logic/burst_addr_seq.sv
// Purpose: Holds the upper burst address and steps it on each burst beat.
// Assumes: load and adv are never asked in the same cycle; load wins if they are.
// Notes:   Wraps within the line, as the memory side expects for line bursts.
module burst_addr_seq (
	input  wire logic  core_clk,
	input  wire logic  rst_n,
	burst_if.seq       bus
);
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (bus.load) begin
			nxt_cnt = bus.seed;
		end else if (bus.adv) begin
			nxt_cnt = cnt_ff + bus_attr_pkg::UPPER_STEP;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= bus_attr_pkg::UPPER_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign bus.cnt = cnt_ff;

	AST_LOAD_SEED: assert property (@(posedge core_clk) disable iff (!rst_n) bus.load |=> cnt_ff == $past(bus.seed))
		else $error("burst counter missed its seed");
endmodule : burst_addr_seq

// File: logic/bus_attribute_burst_addr.sv
// Purpose: Drives transfer attribute lines, start strobe, fetch trace and burst address pins.
// Assumes: Bus arbitration is outside; an internal and an external start never coincide in use.
// Notes:   All pin outputs come from flops; enables are high while this block drives a pin.

// Function
// - Initiator line high for comm-module transfers, low for core transfers.
// - Attribute lines driven only for own transactions, never for external masters.
// - Reservation/trace line marks reservation on data, trace on instruction fetch.
// - Fetch trace output asserted while an instruction fetch is in progress.
// - Start strobe at each internal and external transfer start, and at show-cycle starts in show-cycle mode.
// - Low burst address copies A30 for internal, async external, or sync single-beat starts.
// - Upper burst address copies A28-29 under the same three conditions.
// - During internal or synchronous external bursts, the burst address increments per beat.
// - Internal access to a card slave drives card-space line equal to size bit 0.
// - External access handled by the card interface drives the card space accessed.
// - Core transfers drive privilege line: user or supervisor.
// - Core transfers drive space line: instruction or data.
module bus_attribute_burst_addr (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        int_start,
	input  wire logic        int_from_comm,
	input  wire logic        int_supervisor,
	input  wire logic        int_instr,
	input  wire logic        int_reserve,
	input  wire logic        int_trace,
	input  wire logic        int_burst,
	input  wire logic        int_card,
	input  wire logic        transfer_size_bit0,
	input  wire logic        int_show_start,
	input  wire logic        show_cycle_mode,
	input  wire logic        ext_start,
	input  wire logic        ext_sync,
	input  wire logic        ext_burst,
	input  wire logic        ext_card,
	input  wire logic        ext_card_space,
	input  wire logic [2:0]  addr_bits,
	input  wire logic        beat_done,
	input  wire logic        xfer_done,
	input  wire logic        fetch_active,
	output logic             initiator_type_line,
	output logic             privilege_attr_line,
	output logic             space_attr_line,
	output logic             reservation_trace_line,
	output logic             attr_oe,
	output logic             special_transfer_start,
	output logic             fetch_trace_out,
	output logic             burst_addr_low,
	output logic [1:0]       burst_addr_upper,
	output logic             burst_addr_oe
);
	logic                         rst_meta_ff;
	logic                         rst_n;
	bus_attr_pkg::own_state_e     state_ff, nxt_state;
	logic [3:0]                   attr_ff, nxt_attr;
	logic                         attr_oe_ff, nxt_attr_oe;
	logic                         baddr_oe_ff, nxt_baddr_oe;
	logic                         sts_ff, nxt_sts;
	logic                         trace_ff, nxt_trace;
	logic                         low_ff, nxt_low;
	logic                         inc_ff, nxt_inc;
	logic                         idle;
	burst_if                      bif ();

	// Release is synchronised so no flop leaves reset on a different edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	assign idle = (state_ff == bus_attr_pkg::ST_IDLE);

	always_comb begin
		nxt_state    = state_ff;
		nxt_attr     = attr_ff;
		nxt_attr_oe  = attr_oe_ff;
		nxt_baddr_oe = baddr_oe_ff;
		nxt_low      = low_ff;
		nxt_inc      = inc_ff;
		nxt_sts      = 1'b0;
		nxt_trace    = fetch_active;
		bif.load     = 1'b0;
		bif.adv      = 1'b0;
		bif.seed     = addr_bits[bus_attr_pkg::ADDR_UP_LSB +: bus_attr_pkg::UPPER_W];
		case (state_ff)
			bus_attr_pkg::ST_IDLE: begin
				if (int_start) begin
					nxt_state    = bus_attr_pkg::ST_INT;
					nxt_sts      = 1'b1;
					nxt_attr_oe  = 1'b1;
					nxt_baddr_oe = 1'b1;
					bif.load     = 1'b1;
					nxt_inc      = int_burst;
					nxt_attr     = bus_attr_pkg::ATTR_RST;
					if (int_from_comm) begin
						nxt_attr[bus_attr_pkg::AT_INIT] = bus_attr_pkg::INIT_COMM;
					end else begin
						nxt_attr[bus_attr_pkg::AT_INIT]  = bus_attr_pkg::INIT_CORE;
						nxt_attr[bus_attr_pkg::AT_PRIV]  = int_supervisor;
						nxt_attr[bus_attr_pkg::AT_SPACE] = int_instr;
						nxt_attr[bus_attr_pkg::AT_RESV]  = int_instr ? int_trace : int_reserve;
					end
					nxt_low = int_card ? transfer_size_bit0 : addr_bits[bus_attr_pkg::ADDR_A30];
				end else if (ext_start) begin
					nxt_state    = bus_attr_pkg::ST_EXT;
					nxt_sts      = 1'b1;
					nxt_attr_oe  = 1'b0;
					nxt_baddr_oe = 1'b1;
					bif.load     = 1'b1;
					nxt_inc      = ext_sync & ext_burst;
					nxt_low      = ext_card ? ext_card_space : addr_bits[bus_attr_pkg::ADDR_A30];
				end else if (int_show_start && show_cycle_mode) begin
					nxt_sts = 1'b1;
				end
			end
			bus_attr_pkg::ST_INT, bus_attr_pkg::ST_EXT: begin
				if (xfer_done) begin
					nxt_state    = bus_attr_pkg::ST_IDLE;
					nxt_attr_oe  = 1'b0;
					nxt_baddr_oe = 1'b0;
					nxt_inc      = 1'b0;
				end else if (beat_done && inc_ff) begin
					bif.adv = 1'b1;
				end
			end
			default: begin
				nxt_state    = bus_attr_pkg::ST_IDLE;
				nxt_attr_oe  = 1'b0;
				nxt_baddr_oe = 1'b0;
				nxt_inc      = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= bus_attr_pkg::ST_IDLE;
			attr_ff     <= bus_attr_pkg::ATTR_RST;
			attr_oe_ff  <= bus_attr_pkg::BIT_RST;
			baddr_oe_ff <= bus_attr_pkg::BIT_RST;
			sts_ff      <= bus_attr_pkg::BIT_RST;
			trace_ff    <= bus_attr_pkg::BIT_RST;
			low_ff      <= bus_attr_pkg::BIT_RST;
			inc_ff      <= bus_attr_pkg::BIT_RST;
		end else begin
			state_ff    <= nxt_state;
			attr_ff     <= nxt_attr;
			attr_oe_ff  <= nxt_attr_oe;
			baddr_oe_ff <= nxt_baddr_oe;
			sts_ff      <= nxt_sts;
			trace_ff    <= nxt_trace;
			low_ff      <= nxt_low;
			inc_ff      <= nxt_inc;
		end
	end

	// Low bit is held, not stepped: the stepping happens on the word bits above it
	burst_addr_seq u_seq (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.bus      (bif.seq)
	);

	assign initiator_type_line    = attr_ff[bus_attr_pkg::AT_INIT];
	assign privilege_attr_line    = attr_ff[bus_attr_pkg::AT_PRIV];
	assign space_attr_line        = attr_ff[bus_attr_pkg::AT_SPACE];
	assign reservation_trace_line = attr_ff[bus_attr_pkg::AT_RESV];
	assign attr_oe                = attr_oe_ff;
	assign special_transfer_start = sts_ff;
	assign fetch_trace_out        = trace_ff;
	assign burst_addr_low         = low_ff;
	assign burst_addr_upper       = bif.cnt;
	assign burst_addr_oe          = baddr_oe_ff;

	AST_INIT_TYPE: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && int_start |=> initiator_type_line == $past(int_from_comm) && attr_oe)
		else $error("initiator line wrong after internal start");

	AST_NO_ATTR_EXT: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == bus_attr_pkg::ST_EXT |-> !attr_oe)
		else $error("attribute lines driven during external master cycle");

	AST_RESV_TRACE: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && int_start && !int_from_comm |=>
		reservation_trace_line == ($past(int_instr) ? $past(int_trace) : $past(int_reserve)))
		else $error("reservation trace line wrong");

	AST_FETCH_TRACE: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> fetch_trace_out == $past(fetch_active))
		else $error("fetch trace not following fetch");

	AST_STS_START: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && (int_start || ext_start) |=> special_transfer_start ##1 !special_transfer_start)
		else $error("start strobe not a single pulse at transfer start");

	AST_LOW_COPY: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && ext_start && !int_start && !ext_card |=>
		burst_addr_low == $past(addr_bits[bus_attr_pkg::ADDR_A30]) && burst_addr_oe)
		else $error("low burst bit not copied from A30");

	AST_BURST_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
		!idle && inc_ff && beat_done && !xfer_done |=> burst_addr_upper == $past(burst_addr_upper) + 2'h1)
		else $error("burst address did not step");

	AST_SINGLE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		!idle && !inc_ff |=> $stable(burst_addr_upper))
		else $error("upper burst bits moved outside a burst");

	AST_REG_CARD: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && int_start && int_card |=> burst_addr_low == $past(transfer_size_bit0))
		else $error("card space line differs from size bit 0");

	AST_EXT_CARD: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && !int_start && ext_start && ext_card |=> burst_addr_low == $past(ext_card_space))
		else $error("card space line wrong for external access");

	AST_PRIV_SPACE: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle && int_start && !int_from_comm |=>
		privilege_attr_line == $past(int_supervisor) && space_attr_line == $past(int_instr))
		else $error("privilege or space line wrong");

	AST_HIZ_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		idle |-> !attr_oe && !burst_addr_oe)
		else $error("pins driven while bus not owned");
endmodule : bus_attribute_burst_addr

// File: shared/burst_if.sv
// Purpose: Carries load and advance requests to the burst address sequencer.
// Assumes: Both ends run on the same clock.
// Notes:   cnt comes from a flop in the sequencer.
interface burst_if;
	logic        load;
	logic        adv;
	logic [1:0]  seed;
	logic [1:0]  cnt;

	modport ctl (output load, output adv, output seed, input cnt);
	modport seq (input load, input adv, input seed, output cnt);
endinterface : burst_if

// File: shared/bus_attr_pkg.sv
// Purpose: Shared constants and types for the bus attribute and burst address block.
// Assumes: One 100 MHz clock; address bits are given as {A28, A29, A30}.
// Notes:   Bit positions of the attribute bus and reset values live here only.
package bus_attr_pkg;
	localparam int          ATTR_W        = 4;
	localparam int          UPPER_W       = 2;
	localparam int          ADDR_W        = 3;
	localparam int          AT_INIT       = 0;
	localparam int          AT_PRIV       = 1;
	localparam int          AT_SPACE      = 2;
	localparam int          AT_RESV       = 3;
	localparam int          ADDR_A30      = 0;
	localparam int          ADDR_UP_LSB   = 1;
	localparam logic [3:0]  ATTR_RST      = 4'h0;
	localparam logic [1:0]  UPPER_RST     = 2'h0;
	localparam logic [1:0]  UPPER_STEP    = 2'h1;
	localparam logic        INIT_COMM     = 1'h1;
	localparam logic        INIT_CORE     = 1'h0;
	localparam logic        BIT_RST       = 1'h0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INT,
		ST_EXT
	} own_state_e;
endpackage : bus_attr_pkg

// File: tb/mem_side.sv
// Purpose: Far-side memory model that answers each owned transfer with beat and end pulses.
// Assumes: Outputs change at the falling edge, like the bench.
// Notes:   wait_cyc stretches the answer to act as a slow device; beats counts the last one too.
module mem_side (
	input  wire logic core_clk,
	input  wire logic special_transfer_start,
	input  wire logic burst_addr_oe,
	input  var  int   beats,
	input  var  int   wait_cyc,
	output logic      beat_done,
	output logic      xfer_done
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		beat_done = 1'b0;
		xfer_done = 1'b0;
		forever begin
			@(posedge core_clk iff (special_transfer_start && burst_addr_oe));
			repeat (wait_cyc) @(negedge core_clk);
			for (int i = 0; i < beats; i++) begin
				@(negedge core_clk);
				beat_done = (i < beats - 1);
				xfer_done = (i == beats - 1);
			end
			@(negedge core_clk);
			beat_done = 1'b0;
			xfer_done = 1'b0;
		end
	end
endmodule : mem_side

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the bus attribute and burst address block.
// Assumes: Inputs change at the falling edge; outputs are read at the falling edge.
// Notes:   Attribute lines are only compared while their enable is high.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic       ext, comm, sup, instr, resv, trace, card, sz0, sync;
		logic [2:0] addr;
		logic [3:0] attr;
		logic       aoe, low;
		logic [1:0] up;
	} row_s;
	localparam row_s ROWS [8] = '{
		'{0,0,0,0,1,0,0,0,0,3'h5,4'h8,1,1,2'h2}, '{0,0,1,1,0,1,0,0,0,3'h2,4'he,1,0,2'h1},
		'{0,0,0,1,1,0,0,0,0,3'h7,4'h4,1,1,2'h3}, '{0,1,1,1,1,1,0,0,0,3'h0,4'h1,1,0,2'h0},
		'{0,0,0,0,0,0,1,1,0,3'h4,4'h0,1,1,2'h2}, '{1,0,0,0,0,0,0,0,0,3'h3,4'h0,0,1,2'h1},
		'{1,0,0,0,0,0,0,0,1,3'h6,4'h0,0,0,2'h3}, '{1,0,0,0,0,0,1,1,0,3'h0,4'h0,0,1,2'h0}};
	logic       core_clk = 1'b0, nrst, int_start, int_from_comm, int_supervisor, int_instr, int_reserve;
	logic       int_trace, int_burst, int_card, transfer_size_bit0, int_show_start, show_cycle_mode;
	logic       ext_start, ext_sync, ext_burst, ext_card, ext_card_space, beat_done, xfer_done, fetch_active;
	logic       initiator_type_line, privilege_attr_line, space_attr_line, reservation_trace_line, attr_oe;
	logic       special_transfer_start, fetch_trace_out, burst_addr_low, burst_addr_oe;
	logic [2:0] addr_bits;
	logic [1:0] burst_addr_upper, nb;
	int         beats = 1, wcyc = 0, error_cnt = 0, n_checks = 0;

	always #5 core_clk = ~core_clk;
	// Beat count clears itself whenever the burst pins are released
	always @(posedge core_clk) nb <= burst_addr_oe ? nb + {1'b0, beat_done} : 2'h0;

	bus_attribute_burst_addr bus_attribute_burst_addr_inst (.core_clk, .nrst, .int_start, .int_from_comm,
		.int_supervisor, .int_instr, .int_reserve, .int_trace, .int_burst, .int_card, .transfer_size_bit0,
		.int_show_start, .show_cycle_mode, .ext_start, .ext_sync, .ext_burst, .ext_card, .ext_card_space,
		.addr_bits, .beat_done, .xfer_done, .fetch_active, .initiator_type_line, .privilege_attr_line,
		.space_attr_line, .reservation_trace_line, .attr_oe, .special_transfer_start, .fetch_trace_out,
		.burst_addr_low, .burst_addr_upper, .burst_addr_oe);
	mem_side mem_side_inst (.core_clk, .special_transfer_start, .burst_addr_oe, .beats, .wait_cyc(wcyc),
		.beat_done, .xfer_done);

	task automatic close_out;
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic go(input row_s r, input logic b);
		@(negedge core_clk);
		int_start = !r.ext;
		ext_start = r.ext;
		{int_from_comm, int_supervisor, int_instr, int_reserve, int_trace} = {r.comm, r.sup, r.instr, r.resv, r.trace};
		{int_card, ext_card, transfer_size_bit0, ext_card_space, ext_sync} = {r.card, r.card, r.sz0, r.sz0, r.sync};
		{int_burst, ext_burst, addr_bits} = {b, b, r.addr};
		@(negedge core_clk);
		int_start = 1'b0;
		ext_start = 1'b0;
	endtask : go

	// The burst counter and the low burst bit are compared; the bench keeps its own beat count
	task automatic bcheck(input logic [1:0] s, input logic l);
		for (int k = 0; k < 30 && burst_addr_oe === 1'b1; k++) begin
			chk({1'b0, burst_addr_upper, burst_addr_low}, {1'b0, s + nb, l});
			@(negedge core_clk);
		end
	endtask : bcheck

	initial begin
		nrst = 1'b0;
		{int_start, int_from_comm, int_supervisor, int_instr, int_reserve, int_trace, int_burst} = 7'h0;
		{int_card, transfer_size_bit0, int_show_start, show_cycle_mode, ext_start, ext_sync} = 6'h0;
		{ext_burst, ext_card, ext_card_space, fetch_active, addr_bits} = 7'h0;
		repeat (4) @(negedge core_clk);
		chk({1'b0, attr_oe, burst_addr_oe, special_transfer_start}, 4'h0);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		foreach (ROWS[i]) begin
			go(ROWS[i], 1'b0);
			chk({1'b0, special_transfer_start, attr_oe, burst_addr_oe}, {2'h1, ROWS[i].aoe, 1'b1});
			if (ROWS[i].aoe) chk({reservation_trace_line, space_attr_line, privilege_attr_line,
				initiator_type_line}, ROWS[i].attr);
			chk({1'b0, burst_addr_upper, burst_addr_low}, {1'b0, ROWS[i].up, ROWS[i].low});
			@(negedge core_clk);
			chk({3'h0, special_transfer_start}, 4'h0);
			for (int k = 0; k < 20 && burst_addr_oe !== 1'b0; k++) @(negedge core_clk);
			chk({2'h0, attr_oe, burst_addr_oe}, 4'h0);
		end
		beats = 4;
		wcyc = 2;
		go('{0,0,0,0,0,0,0,0,0,3'h6,4'h0,1,0,2'h3}, 1'b1);
		bcheck(2'h3, 1'b0);
		go('{1,0,0,0,0,0,0,0,1,3'h1,4'h0,0,1,2'h0}, 1'b1);
		bcheck(2'h0, 1'b1);
		fetch_active = 1'b1;
		@(negedge core_clk);
		chk({3'h0, fetch_trace_out}, 4'h1);
		fetch_active = 1'b0;
		@(negedge core_clk);
		chk({3'h0, fetch_trace_out}, 4'h0);
		for (int m = 0; m < 2; m++) begin
			show_cycle_mode = m[0];
			int_show_start = 1'b1;
			@(negedge core_clk);
			int_show_start = 1'b0;
			chk({2'h0, special_transfer_start, attr_oe}, {2'h0, m[0], 1'b0});
			@(negedge core_clk);
		end
		// Reset in mid-transfer must float the pins at once
		go(ROWS[0], 1'b0);
		nrst = 1'b0;
		#1;
		chk({2'h0, attr_oe, burst_addr_oe}, 4'h0);
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		go(ROWS[2], 1'b0);
		chk({1'b0, special_transfer_start, attr_oe, burst_addr_oe}, 4'h7);
		chk({reservation_trace_line, space_attr_line, privilege_attr_line, initiator_type_line}, 4'h4);
		close_out();
	end

	initial begin
		#20000;
		error_cnt++;
		close_out();
	end
endmodule : tb_top
